// ---- common/tecc_pkg.sv ----
// Constants, types and helpers of the thermal event configuration block
package tecc_pkg;

	// ------------------------------------------------------------
	// Register port
	// ------------------------------------------------------------
	localparam int unsigned DATA_W = 16;
	localparam logic [7:0] ADDR_CONFIG = 8'h01;
	localparam logic [7:0] ADDR_UPPER = 8'h02;
	localparam logic [7:0] ADDR_LOWER = 8'h03;
	localparam logic [7:0] ADDR_CRIT = 8'h04;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [15:0] CONFIG_RESET = 16'h0000;
	localparam logic [15:0] THR_RESET = 16'h0000;
	localparam logic [15:0] READ_IDLE = 16'h0000;

	// ------------------------------------------------------------
	// Configuration field positions
	// ------------------------------------------------------------
	localparam int unsigned BIT_MODE = 0;
	localparam int unsigned BIT_POL = 1;
	localparam int unsigned BIT_CRIT_ONLY = 2;
	localparam int unsigned BIT_ENABLE = 3;
	localparam int unsigned BIT_STATUS = 4;
	localparam int unsigned BIT_CLEAR = 5;
	localparam int unsigned BIT_LOCK_WIN = 6;
	localparam int unsigned BIT_LOCK_CRIT = 7;
	localparam int unsigned BIT_SHUTDOWN = 8;
	localparam int unsigned BIT_HYST_LO = 9;
	localparam int unsigned BIT_HYST_HI = 10;
	localparam int unsigned BIT_RSVD_LO = 11;
	localparam int unsigned BIT_RSVD_HI = 15;

	// Threshold bits that exist: sign at 12, LSB 0.25 degree at 2
	localparam logic [15:0] THR_MASK = 16'h1FFC;

	// ------------------------------------------------------------
	// Hysteresis, in eighths of a degree
	// ------------------------------------------------------------
	localparam logic [1:0] HYST_OFF = 2'h0;
	localparam logic [1:0] HYST_1P5 = 2'h1;
	localparam logic [1:0] HYST_3 = 2'h2;
	localparam logic [1:0] HYST_6 = 2'h3;
	localparam logic signed [13:0] HYST_E_OFF = 14'sh0000;
	localparam logic signed [13:0] HYST_E_1P5 = 14'sh000C;
	localparam logic signed [13:0] HYST_E_3 = 14'sh0018;
	localparam logic signed [13:0] HYST_E_6 = 14'sh0030;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef logic signed [13:0] tecc_temp_t;
	typedef enum logic [1:0] {TRIP_ABOVE, TRIP_BELOW, TRIP_CRIT} tecc_kind_t;

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	// Threshold word to eighths of a degree, sign extended
	function automatic tecc_temp_t thrToEighths(input logic [15:0] thr);
		return tecc_temp_t'({{2{thr[12]}}, thr[12:2], 1'b0});
	endfunction : thrToEighths

	// Temperature word to eighths of a degree, sign extended
	function automatic tecc_temp_t tempToEighths(input logic [15:0] t);
		return tecc_temp_t'({{2{t[12]}}, t[12:1]});
	endfunction : tempToEighths

	// Hysteresis field to eighths of a degree
	function automatic tecc_temp_t hystEighths(input logic [1:0] sel);
		tecc_temp_t h;
		h = HYST_E_OFF;
		case (sel)
			HYST_1P5: h = HYST_E_1P5;
			HYST_3: h = HYST_E_3;
			HYST_6: h = HYST_E_6;
			default: h = HYST_E_OFF;
		endcase
		return h;
	endfunction : hystEighths

endpackage : tecc_pkg

// ---- hdl/tecc_trip_cmp.sv ----
// One threshold comparator with hysteresis and a held trip flag
`timescale 1ns/1ps
module tecc_trip_cmp (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// Comparison
	input wire tecc_pkg::tecc_kind_t kind,
	input wire tecc_pkg::tecc_temp_t temp,
	input wire tecc_pkg::tecc_temp_t thr,
	input wire tecc_pkg::tecc_temp_t hyst,
	input wire logic evalEn,
	// Result
	output logic trip
);

	tecc_pkg::tecc_temp_t lowEdge;
	logic setCond;
	logic clrCond;

	assign lowEdge = tecc_pkg::tecc_temp_t'(thr - hyst);

	// ------------------------------------------------------------
	// Set and clear conditions
	// ------------------------------------------------------------
	always_comb begin
		setCond = 1'b0;
		clrCond = 1'b0;
		case (kind)
			tecc_pkg::TRIP_ABOVE: begin
				setCond = temp > thr;
				clrCond = temp <= lowEdge;
			end
			tecc_pkg::TRIP_BELOW: begin
				setCond = temp <= lowEdge;
				clrCond = temp >= thr;
			end
			tecc_pkg::TRIP_CRIT: begin
				setCond = temp >= thr;
				clrCond = temp < lowEdge;
			end
			default: begin
				setCond = 1'b0;
				clrCond = 1'b0;
			end
		endcase
	end

	// ------------------------------------------------------------
	// Held flag, clear first so equality without hysteresis clears, except on the critical flag
	// ------------------------------------------------------------
	// clear before set
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			trip <= 1'b0;
		end else if (evalEn) begin
			if (clrCond) begin
				trip <= 1'b0;
			end else if (setCond) begin
				trip <= 1'b1;
			end
		end
	end

endmodule : tecc_trip_cmp

// ---- hdl/tecc_config_ctrl.sv ----
// Configuration, thresholds and alert control of the thermal monitor
// Operation
// - Bit 0 picks comparator or latched mode
// - Bit 1 sets alert polarity
// - Locks freeze mode, polarity and enable
// - Bit 2 limits alert to critical
// - Only window lock freezes critical-only
// - Bit 3 enables alert, else inactive
// - Bit 4 reads alert asserted, read only
// - Bit 5 clears latched alert, reads 0
// - Window lock freezes window thresholds, sticky
// - Critical lock freezes critical threshold, sticky
// - Lock write updates other bits too
// - Bit 8 stops sensing and alerts
// - Locked shutdown may clear, not set
// - Bits 10:9 select hysteresis amount
// - Locks freeze hysteresis field
// - Hysteresis applies to window and critical
// - Below flag clears at, sets under
// - Reserved bits 15:11 read zero
// - Upper threshold is quarter degree signed
// - Unused threshold bits stay zero
// - Comparator alert follows window, ignores access
// - Critical alert holds until below
`timescale 1ns/1ps
module tecc_config_ctrl (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// Register port
	input wire logic regWrEn,
	input wire logic regRdEn,
	input wire logic [7:0] regAddr,
	input wire logic [15:0] regWrData,
	output logic [15:0] regRdData,
	output logic regRdValid,
	// Sensor side
	input wire logic [15:0] tempIn,
	input wire logic tempValid,
	output logic sensorShutdown,
	// Trip status
	output logic tripAbove,
	output logic tripBelow,
	output logic tripCrit,
	// Alert pin
	output logic eventOut,
	output logic eventOe
);

	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	logic cfgMode_q;
	logic cfgPol_q;
	logic cfgCritOnly_q;
	logic cfgEnable_q;
	logic lockWin_q;
	logic lockCrit_q;
	logic cfgShutdown_q;
	logic [1:0] cfgHyst_q;
	logic [15:0] upperThr_q;
	logic [15:0] lowerThr_q;
	logic [15:0] critThr_q;
	tecc_pkg::tecc_temp_t temp_q;
	logic prevAbove_q;
	logic prevBelow_q;
	logic winLatch_q;
	logic eventStat_q;
	logic eventOut_q;
	logic eventOe_q;
	logic [15:0] regRdData_q;
	logic regRdValid_q;
	logic cfgWrite;
	logic locked;
	logic clearPulse;
	logic windowEdge;
	logic assertedD;
	logic activeD;
	logic [15:0] cfgWord;
	logic [15:0] rdMux;
	tecc_pkg::tecc_temp_t hystE;

	assign cfgWrite = regWrEn && (regAddr == tecc_pkg::ADDR_CONFIG);
	assign locked = lockWin_q || lockCrit_q;
	assign clearPulse = cfgWrite && regWrData[tecc_pkg::BIT_CLEAR];

	// ------------------------------------------------------------
	// Configuration register
	// ------------------------------------------------------------
	// per-field protection, old lock values
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			cfgMode_q <= tecc_pkg::CONFIG_RESET[tecc_pkg::BIT_MODE];
			cfgPol_q <= tecc_pkg::CONFIG_RESET[tecc_pkg::BIT_POL];
			cfgCritOnly_q <= tecc_pkg::CONFIG_RESET[tecc_pkg::BIT_CRIT_ONLY];
			cfgEnable_q <= tecc_pkg::CONFIG_RESET[tecc_pkg::BIT_ENABLE];
			cfgShutdown_q <= tecc_pkg::CONFIG_RESET[tecc_pkg::BIT_SHUTDOWN];
			cfgHyst_q <= tecc_pkg::CONFIG_RESET[tecc_pkg::BIT_HYST_HI:
				tecc_pkg::BIT_HYST_LO];
		end else if (cfgWrite) begin
			if (!locked) begin
				cfgMode_q <= regWrData[tecc_pkg::BIT_MODE];
				cfgPol_q <= regWrData[tecc_pkg::BIT_POL];
				cfgEnable_q <= regWrData[tecc_pkg::BIT_ENABLE];
			end
			if (!lockWin_q) begin
				cfgCritOnly_q <= regWrData[tecc_pkg::BIT_CRIT_ONLY];
			end
			if (locked) begin
				cfgShutdown_q <= cfgShutdown_q &&
					regWrData[tecc_pkg::BIT_SHUTDOWN];
			end else begin
				cfgShutdown_q <= regWrData[tecc_pkg::BIT_SHUTDOWN];
			end
			if (!locked) begin
				cfgHyst_q <= regWrData[tecc_pkg::BIT_HYST_HI:
					tecc_pkg::BIT_HYST_LO];
			end
		end
	end

	// ------------------------------------------------------------
	// Lock bits, cleared only by reset
	// ------------------------------------------------------------
	// sticky locks, same write
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			lockWin_q <= tecc_pkg::CONFIG_RESET[tecc_pkg::BIT_LOCK_WIN];
			lockCrit_q <= tecc_pkg::CONFIG_RESET[tecc_pkg::BIT_LOCK_CRIT];
		end else if (cfgWrite) begin
			lockWin_q <= lockWin_q || regWrData[tecc_pkg::BIT_LOCK_WIN];
			lockCrit_q <= lockCrit_q || regWrData[tecc_pkg::BIT_LOCK_CRIT];
		end
	end

	// ------------------------------------------------------------
	// Threshold registers
	// ------------------------------------------------------------
	// locked writes dropped, unused bits zero
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			upperThr_q <= tecc_pkg::THR_RESET;
			lowerThr_q <= tecc_pkg::THR_RESET;
			critThr_q <= tecc_pkg::THR_RESET;
		end else if (regWrEn) begin
			if (regAddr == tecc_pkg::ADDR_UPPER && !lockWin_q) begin
				upperThr_q <= regWrData & tecc_pkg::THR_MASK;
			end
			if (regAddr == tecc_pkg::ADDR_LOWER && !lockWin_q) begin
				lowerThr_q <= regWrData & tecc_pkg::THR_MASK;
			end
			if (regAddr == tecc_pkg::ADDR_CRIT && !lockCrit_q) begin
				critThr_q <= regWrData & tecc_pkg::THR_MASK;
			end
		end
	end

	// ------------------------------------------------------------
	// Sample capture and comparisons
	// ------------------------------------------------------------
	// no new samples in shutdown
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			temp_q <= tecc_pkg::tempToEighths(tecc_pkg::THR_RESET);
		end else if (tempValid && !cfgShutdown_q) begin
			temp_q <= tecc_pkg::tempToEighths(tempIn);
		end
	end

	assign hystE = tecc_pkg::hystEighths(cfgHyst_q);

	tecc_trip_cmp aboveCmp (
		.mclk(mclk),
		.rst_n(rst_n),
		.kind(tecc_pkg::TRIP_ABOVE),
		.temp(temp_q),
		.thr(tecc_pkg::thrToEighths(upperThr_q)),
		.hyst(hystE),
		.evalEn(!cfgShutdown_q),
		.trip(tripAbove)
	);

	tecc_trip_cmp belowCmp (
		.mclk(mclk),
		.rst_n(rst_n),
		.kind(tecc_pkg::TRIP_BELOW),
		.temp(temp_q),
		.thr(tecc_pkg::thrToEighths(lowerThr_q)),
		.hyst(hystE),
		.evalEn(!cfgShutdown_q),
		.trip(tripBelow)
	);

	tecc_trip_cmp critCmp (
		.mclk(mclk),
		.rst_n(rst_n),
		.kind(tecc_pkg::TRIP_CRIT),
		.temp(temp_q),
		.thr(tecc_pkg::thrToEighths(critThr_q)),
		.hyst(hystE),
		.evalEn(!cfgShutdown_q),
		.trip(tripCrit)
	);

	// ------------------------------------------------------------
	// Window crossing latch
	// ------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			prevAbove_q <= 1'b0;
			prevBelow_q <= 1'b0;
		end else begin
			prevAbove_q <= tripAbove;
			prevBelow_q <= tripBelow;
		end
	end

	assign windowEdge = (tripAbove ^ prevAbove_q) || (tripBelow ^ prevBelow_q);

	// set wins over clear, comparator mode ignores clear
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			winLatch_q <= 1'b0;
		end else if (windowEdge && cfgMode_q && !cfgCritOnly_q) begin
			winLatch_q <= 1'b1;
		end else if (clearPulse && cfgMode_q) begin
			winLatch_q <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Alert condition and pin
	// ------------------------------------------------------------
	// alert source selection
	always_comb begin
		if (cfgShutdown_q) begin
			assertedD = 1'b0;
		end else if (cfgCritOnly_q) begin
			assertedD = tripCrit;
		end else if (cfgMode_q) begin
			assertedD = tripCrit || winLatch_q;
		end else begin
			assertedD = tripCrit || tripAbove || tripBelow;
		end
	end

	assign activeD = assertedD && cfgEnable_q;

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			eventStat_q <= 1'b0;
			eventOe_q <= 1'b0;
			eventOut_q <= 1'b1;
		end else begin
			eventStat_q <= activeD;
			eventOe_q <= cfgEnable_q;
			eventOut_q <= cfgPol_q ? activeD : !activeD;
		end
	end

	assign eventOut = eventOut_q;
	assign eventOe = eventOe_q;
	assign sensorShutdown = cfgShutdown_q;

	// ------------------------------------------------------------
	// Read path
	// ------------------------------------------------------------
	// status live, clear and reserved read zero
	always_comb begin
		cfgWord = 16'h0000;
		cfgWord[tecc_pkg::BIT_MODE] = cfgMode_q;
		cfgWord[tecc_pkg::BIT_POL] = cfgPol_q;
		cfgWord[tecc_pkg::BIT_CRIT_ONLY] = cfgCritOnly_q;
		cfgWord[tecc_pkg::BIT_ENABLE] = cfgEnable_q;
		cfgWord[tecc_pkg::BIT_STATUS] = eventStat_q;
		cfgWord[tecc_pkg::BIT_LOCK_WIN] = lockWin_q;
		cfgWord[tecc_pkg::BIT_LOCK_CRIT] = lockCrit_q;
		cfgWord[tecc_pkg::BIT_SHUTDOWN] = cfgShutdown_q;
		cfgWord[tecc_pkg::BIT_HYST_HI:tecc_pkg::BIT_HYST_LO] = cfgHyst_q;
	end

	always_comb begin
		case (regAddr)
			tecc_pkg::ADDR_CONFIG: rdMux = cfgWord;
			tecc_pkg::ADDR_UPPER: rdMux = upperThr_q;
			tecc_pkg::ADDR_LOWER: rdMux = lowerThr_q;
			tecc_pkg::ADDR_CRIT: rdMux = critThr_q;
			default: rdMux = tecc_pkg::READ_IDLE;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			regRdData_q <= tecc_pkg::READ_IDLE;
			regRdValid_q <= 1'b0;
		end else begin
			regRdValid_q <= regRdEn;
			if (regRdEn) begin
				regRdData_q <= rdMux;
			end
		end
	end

	assign regRdData = regRdData_q;
	assign regRdValid = regRdValid_q;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	sequence lockedCfgWrite;
		cfgWrite && locked;
	endsequence

	sequence freeLockWrite;
		cfgWrite && !locked && regWrData[tecc_pkg::BIT_LOCK_WIN];
	endsequence

	sequence intClear;
		clearPulse && cfgMode_q && !windowEdge;
	endsequence

	lockMode_a: assert property (
		lockedCfgWrite |=> $stable(cfgMode_q) && $stable(cfgPol_q) &&
			$stable(cfgEnable_q) && $stable(cfgHyst_q))
		else $error("locked write changed a protected field");

	critOnlyFree_a: assert property (
		cfgWrite && lockCrit_q && !lockWin_q |=>
			cfgCritOnly_q == $past(regWrData[tecc_pkg::BIT_CRIT_ONLY]))
		else $error("critical-only not written under critical lock");

	critOnlyLock_a: assert property (
		cfgWrite && lockWin_q |=> $stable(cfgCritOnly_q))
		else $error("critical-only changed under window lock");

	lockSticky_a: assert property (
		lockWin_q ##1 regWrEn && regAddr == tecc_pkg::ADDR_UPPER |=>
			lockWin_q && $stable(upperThr_q))
		else $error("window lock dropped or threshold changed");

	critThrLock_a: assert property (
		lockCrit_q && regWrEn && regAddr == tecc_pkg::ADDR_CRIT |=>
			lockCrit_q && $stable(critThr_q))
		else $error("critical threshold changed while locked");

	sameWrite_a: assert property (
		freeLockWrite |=> lockWin_q &&
			cfgMode_q == $past(regWrData[tecc_pkg::BIT_MODE]) &&
			cfgEnable_q == $past(regWrData[tecc_pkg::BIT_ENABLE]))
		else $error("lock write did not update other bits");

	shutClear_a: assert property (
		cfgWrite && !regWrData[tecc_pkg::BIT_SHUTDOWN] |=> !cfgShutdown_q)
		else $error("shutdown not cleared by write");

	shutQuiet_a: assert property (
		$past(cfgShutdown_q) |-> !eventStat_q &&
			eventOut_q == !$past(cfgPol_q))
		else $error("alert active during shutdown");

	disabledIdle_a: assert property (
		$past(!cfgEnable_q) |-> !eventOe_q && !eventStat_q)
		else $error("disabled alert not idle");

	clearLatch_a: assert property (
		intClear |=> !winLatch_q)
		else $error("clear did not drop latched alert");

	readZero_a: assert property (
		regRdEn && regAddr == tecc_pkg::ADDR_CONFIG |=> regRdValid_q &&
			regRdData_q[tecc_pkg::BIT_RSVD_HI:tecc_pkg::BIT_RSVD_LO] == 5'h00
			&& !regRdData_q[tecc_pkg::BIT_CLEAR])
		else $error("reserved or clear bit read nonzero");

	thrUnused_a: assert property (
		(upperThr_q & ~tecc_pkg::THR_MASK) == 16'h0000)
		else $error("unused threshold bits set");

	compFollow_a: assert property (
		$past(cfgEnable_q && !cfgMode_q && !cfgCritOnly_q &&
			!cfgShutdown_q) |->
			eventStat_q == $past(tripAbove || tripBelow || tripCrit))
		else $error("comparator alert not following window");

endmodule : tecc_config_ctrl

// ---- sim/tecc_host_model.sv ----
// Host-side register master for the thermal event configuration block
`timescale 1ns/1ps
module tecc_host_model (
	// Clock
	input wire logic mclk,
	// Register port
	output logic regWrEn,
	output logic regRdEn,
	output logic [7:0] regAddr,
	output logic [15:0] regWrData,
	input wire logic [15:0] regRdData,
	input wire logic regRdValid
);
	initial begin
		regWrEn = 1'b0;
		regRdEn = 1'b0;
		regAddr = 8'hFF;
		regWrData = 16'h0000;
	end

	// ------------------------------------------------------------
	// Register cycles
	// ------------------------------------------------------------
	// reserved config bits sent as zero
	task automatic wrReg(input logic [7:0] a, input logic [15:0] d);
		@(posedge mclk);
		regWrEn <= 1'b1;
		regAddr <= a;
		regWrData <= (a == tecc_pkg::ADDR_CONFIG) ? (d & 16'h07FF) : d;
		@(posedge mclk);
		regWrEn <= 1'b0;
		regAddr <= ~a;
		regWrData <= ~d;
	endtask : wrReg

	// Read data taken exactly one cycle after the strobe
	task automatic rdReg(input logic [7:0] a, output logic [15:0] d);
		@(posedge mclk);
		regRdEn <= 1'b1;
		regAddr <= a;
		@(posedge mclk);
		regRdEn <= 1'b0;
		regAddr <= ~a;
		#1;
		d = (regRdValid === 1'b1) ? regRdData : 16'hXXXX;
	endtask : rdReg
endmodule : tecc_host_model

// ---- sim/tecc_config_ctrl_test.sv ----
// Self-checking bench for the thermal event configuration block
`timescale 1ns/1ps
module tecc_config_ctrl_test;
	logic mclk, rst_n, regWrEn, regRdEn, regRdValid, tempValid;
	logic [7:0] regAddr;
	logic [15:0] regWrData, regRdData, tempIn;
	logic sensorShutdown, tripAbove, tripBelow, tripCrit;
	logic eventOut, eventOe;
	int n_errors = 0;
	int n_compared = 0;
	int cycles = 0;
	int hTab[4] = '{0, 12, 24, 48};

	tecc_config_ctrl uut (
		.mclk(mclk), .rst_n(rst_n),
		.regWrEn(regWrEn), .regRdEn(regRdEn), .regAddr(regAddr),
		.regWrData(regWrData), .regRdData(regRdData),
		.regRdValid(regRdValid), .tempIn(tempIn), .tempValid(tempValid),
		.sensorShutdown(sensorShutdown), .tripAbove(tripAbove),
		.tripBelow(tripBelow), .tripCrit(tripCrit),
		.eventOut(eventOut), .eventOe(eventOe)
	);

	tecc_host_model host (
		.mclk(mclk), .regWrEn(regWrEn), .regRdEn(regRdEn),
		.regAddr(regAddr), .regWrData(regWrData),
		.regRdData(regRdData), .regRdValid(regRdValid)
	);

	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	task automatic wrap_up();
		$display("errors %0d compared %0d", n_errors, n_compared);
		if (n_errors == 0 && n_compared > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : wrap_up

	task automatic settle();
		repeat (5) @(posedge mclk);
		#1;
	endtask : settle

	task automatic doRst();
		@(posedge mclk);
		rst_n <= 1'b0;
		repeat (16) @(posedge mclk);
		rst_n <= 1'b1;
	endtask : doRst

	task automatic chkReg(input string nm, input logic [7:0] a,
		input logic [15:0] exp);
		logic [15:0] got;
		host.rdReg(a, got);
		n_compared++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch %s exp %h got %h", nm, exp, got);
		end
	endtask : chkReg

	task automatic chkPin(input string nm, input logic exp,
		input logic got);
		n_compared++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch %s exp %b got %b", nm, exp, got);
		end
	endtask : chkPin

	task automatic flags(input logic a, input logic b, input logic c,
		input logic e);
		chkPin("above", a, tripAbove);
		chkPin("below", b, tripBelow);
		chkPin("crit", c, tripCrit);
		chkPin("event", e, eventOut);
	endtask : flags

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		host.wrReg(a, d);
		settle();
	endtask : wr

	task automatic wCfg(input logic [15:0] d);
		wr(tecc_pkg::ADDR_CONFIG, d);
	endtask : wCfg

	task automatic cCfg(input logic [15:0] exp);
		chkReg("config", tecc_pkg::ADDR_CONFIG, exp);
	endtask : cCfg

	// Temperature in eighths of a degree
	task automatic sample(input int e);
		logic [15:0] w;
		w = 16'(e * 2) & 16'h1FFE;
		@(posedge mclk);
		tempIn <= w;
		tempValid <= 1'b1;
		@(posedge mclk);
		tempValid <= 1'b0;
		tempIn <= ~w;
		settle();
	endtask : sample

	initial begin
		while (cycles < 6000) begin
			@(posedge mclk);
			cycles++;
		end
		n_errors++;
		wrap_up();
	end

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		rst_n = 1'b0;
		tempIn = 16'h0000;
		tempValid = 1'b0;
		doRst();
		cCfg(16'h0000);
		chkPin("oe", 1'b0, eventOe);
		chkPin("event", 1'b1, eventOut);
		wr(tecc_pkg::ADDR_UPPER, 16'hFFFF);
		chkReg("upper", tecc_pkg::ADDR_UPPER, 16'h1FFC);
		wr(tecc_pkg::ADDR_UPPER, 16'h1000);
		chkReg("upper", tecc_pkg::ADDR_UPPER, 16'h1000);
		chkReg("unmapped", 8'h09, 16'h0000);
		wr(tecc_pkg::ADDR_CRIT, 16'h0640);
		wr(tecc_pkg::ADDR_LOWER, 16'h00A0);
		wr(tecc_pkg::ADDR_UPPER, 16'h0190);
		// Comparator mode, polarity, enable
		wCfg(16'h0008);
		sample(160);
		flags(1'b0, 1'b0, 1'b0, 1'b1);
		chkPin("oe", 1'b1, eventOe);
		sample(240);
		flags(1'b1, 1'b0, 1'b0, 1'b0);
		cCfg(16'h0018);
		chkPin("event", 1'b0, eventOut);
		wCfg(16'h0028);
		cCfg(16'h0018);
		chkPin("event", 1'b0, eventOut);
		wCfg(16'h000A);
		chkPin("event", 1'b1, eventOut);
		cCfg(16'h001A);
		wCfg(16'h0002);
		chkPin("oe", 1'b0, eventOe);
		chkPin("event", 1'b0, eventOut);
		cCfg(16'h0002);
		// Critical only and critical hysteresis
		wCfg(16'h000C);
		chkPin("event", 1'b1, eventOut);
		sample(800);
		flags(1'b1, 1'b0, 1'b1, 1'b0);
		sample(752);
		flags(1'b1, 1'b0, 1'b0, 1'b1);
		wCfg(16'h060C);
		sample(800);
		sample(752);
		flags(1'b1, 1'b0, 1'b1, 1'b0);
		sample(751);
		flags(1'b1, 1'b0, 1'b0, 1'b1);
		// Every hysteresis code on the upper bound
		for (int i = 0; i < 4; i++) begin
			wCfg(16'h0008 | 16'(i << 9));
			sample(240);
			sample(201 - hTab[i]);
			chkPin("above", 1'b1, tripAbove);
			sample(200 - hTab[i]);
			chkPin("above", 1'b0, tripAbove);
		end
		wCfg(16'h0408);
		sample(57);
		chkPin("below", 1'b0, tripBelow);
		sample(56);
		chkPin("below", 1'b1, tripBelow);
		sample(79);
		chkPin("below", 1'b1, tripBelow);
		sample(80);
		chkPin("below", 1'b0, tripBelow);
		// Interrupt mode latch and clear
		wCfg(16'h0009);
		wCfg(16'h0029);
		chkPin("event", 1'b1, eventOut);
		sample(240);
		flags(1'b1, 1'b0, 1'b0, 1'b0);
		sample(160);
		flags(1'b0, 1'b0, 1'b0, 1'b0);
		wCfg(16'h0029);
		chkPin("event", 1'b1, eventOut);
		cCfg(16'h0009);
		// Shutdown
		wCfg(16'h0008);
		sample(240);
		chkPin("event", 1'b0, eventOut);
		wCfg(16'h0108);
		chkPin("shutdown", 1'b1, sensorShutdown);
		chkPin("event", 1'b1, eventOut);
		sample(160);
		chkPin("above", 1'b1, tripAbove);
		wCfg(16'h0008);
		chkPin("shutdown", 1'b0, sensorShutdown);
		chkPin("event", 1'b0, eventOut);
		// Window lock
		doRst();
		wr(tecc_pkg::ADDR_CRIT, 16'h0640);
		wCfg(16'h034B);
		cCfg(16'h034B);
		wCfg(16'h0004);
		cCfg(16'h024B);
		wCfg(16'h0100);
		cCfg(16'h024B);
		wr(tecc_pkg::ADDR_UPPER, 16'h0190);
		chkReg("upper", tecc_pkg::ADDR_UPPER, 16'h0000);
		wr(tecc_pkg::ADDR_LOWER, 16'h00A0);
		chkReg("lower", tecc_pkg::ADDR_LOWER, 16'h0000);
		// Critical lock
		doRst();
		cCfg(16'h0000);
		wCfg(16'h0080);
		wCfg(16'h0085);
		cCfg(16'h0084);
		wr(tecc_pkg::ADDR_CRIT, 16'h0640);
		chkReg("crit", tecc_pkg::ADDR_CRIT, 16'h0000);
		wr(tecc_pkg::ADDR_UPPER, 16'h0190);
		chkReg("upper", tecc_pkg::ADDR_UPPER, 16'h0190);
		wrap_up();
	end
endmodule : tecc_config_ctrl_test
